// ===== aims_pkg.sv
// Shared constants and types for the ADC input multiplexer sequencer
package aims_pkg;
    // Frame geometry
    localparam int NUM_SLOTS = 11;
    localparam logic [3:0] SLOT_MAX = 4'hB;
    localparam logic [3:0] SLOT_ZERO = 4'h0;

    // Register indices; byte address is four times the index
    localparam logic [13:0] IDX_COUNT_S10 = 14'h2100;
    localparam logic [13:0] IDX_S8_S9 = 14'h2101;
    localparam logic [13:0] IDX_S6_S7 = 14'h2102;
    localparam logic [13:0] IDX_S4_S5 = 14'h2103;
    localparam logic [13:0] IDX_S2_S3 = 14'h2104;
    localparam logic [13:0] IDX_S0_S1 = 14'h2105;
    localparam logic [13:0] IDX_DIFF_FILT = 14'h210C;
    localparam logic [13:0] IDX_PREAMP = 14'h2704;
    localparam logic [13:0] IDX_REMOTE = 14'h2709;
    localparam logic [13:0] IDX_CONTROL = 14'h2110;
    localparam logic [13:0] IDX_STATUS = 14'h2111;
    localparam logic [13:0] IDX_FRAMES = 14'h2112;

    // Writable byte registers, in generate order
    localparam int NUM_WREG = 10;
    localparam int W_DIFF = 6;
    localparam int W_PREAMP = 7;
    localparam int W_REMOTE = 8;
    localparam int W_CONTROL = 9;
    localparam logic [13:0] WREG_IDX [NUM_WREG] = '{
        IDX_COUNT_S10, IDX_S8_S9, IDX_S6_S7, IDX_S4_S5, IDX_S2_S3,
        IDX_S0_S1, IDX_DIFF_FILT, IDX_PREAMP, IDX_REMOTE, IDX_CONTROL};
    localparam logic [7:0] WREG_RESET = 8'h00;

    // Field positions
    localparam int COUNT_LSB = 4;
    localparam int DIFF_LSB = 4;
    localparam int FILT_LSB = 1;
    localparam int PREAMP_BIT = 5;
    localparam int REMOTE_LSB = 3;
    localparam int RUN_BIT = 0;

    // Source codes
    localparam logic [3:0] SRC_FIRST_PAIR = 4'h0;
    localparam logic [3:0] SRC_PHASE_A = 4'h8;
    localparam logic [3:0] SRC_PHASE_B = 4'h9;
    localparam logic [3:0] SRC_PHASE_C = 4'hA;

    // Compute engine sample slots; remote channels follow the local slots
    localparam logic [3:0] CE_REMOTE_BASE = 4'hB;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_PICK = 2'b01,
        ST_CONV = 2'b10
    } aims_state_t;
endpackage : aims_pkg

// ===== aims_byte_reg.sv
// One software-writable byte register with reset value
module aims_byte_reg #(
    parameter logic [7:0] RESET = 8'h00
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic wrEn,
    input wire logic [7:0] wrData,
    output logic [7:0] value
);
    // Stored byte, updated only on a completed write
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            value <= RESET;
        end else if (wrEn) begin
            value <= wrData;
        end
    end
endmodule : aims_byte_reg

// ===== aims_top.sv
// Input multiplexer sequencer with APB registers and sample write-back
// Operation
// - One analog input at a time goes to the converter, slot by slot, each slot picked by its own 4-bit select field out of eleven.
// - Every frame starts at slot 0 and runs until the counted number of slots is done.
// - The slot count per frame is the 4-bit field in bits 7 to 4 of the byte at 0x2100.
// - Up to eleven sources per frame single-ended, seven when the current inputs are paired.
// - Select code 0 routes the first current pair.
// - Select code 8 routes the phase A voltage input.
// - Select code 9 routes the phase B voltage input.
// - Select code A routes the phase C voltage input.
// - Bits 3, 4 and 5 of the byte at 0x2709 move the second, third and fourth pairs to the remote sensor link.
// - Bits 4 to 7 of the byte at 0x210C make the four current pairs differential.
// - Bit 5 of the byte at 0x2704 puts the first pair through a gain of 8.
// - Remote samples skip the multiplexer and go straight to engine memory.
//
// The APB register port was chosen for this implementation.
module aims_top
    import aims_pkg::*;
#(
    parameter int SAMPLE_W = 24
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [15:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic convDone,
    input wire logic [SAMPLE_W-1:0] convData,
    input wire logic remoteValid,
    input wire logic [1:0] remoteChan,
    input wire logic [SAMPLE_W-1:0] remoteData,
    output logic convStart,
    output logic [3:0] muxSelect,
    output logic [aims_pkg::NUM_SLOTS-1:0] muxOneHot,
    output logic preampGain8,
    output logic [3:0] pairDifferential,
    output logic [2:0] pairRemote,
    output logic [1:0] filterLength,
    output logic frameDone,
    output logic ceWriteEn,
    output logic [3:0] ceWriteAddr,
    output logic [SAMPLE_W-1:0] ceWriteData
);
    import aims_pkg::*;

    // Sample width must fit the read path and the write-back bus
    if (SAMPLE_W < 8 || SAMPLE_W > 32) begin : gen_bad_width
        $error("aims_top: SAMPLE_W out of range");
    end

    // ---------------- APB slave ----------------
    logic readyReg;
    logic readyNext;
    logic errReg;
    logic [31:0] rdataReg;
    wire accessWait = psel & penable & ~readyReg;
    wire apbCommit = psel & penable & readyReg;
    wire wordAligned = (paddr[1:0] == 2'b00);
    wire [13:0] regIdx = paddr[15:2];

    // Register byte storage
    logic [7:0] regVal [NUM_WREG];
    logic [NUM_WREG-1:0] addrHit;

    // One wait state: data and error are captured on the same edge that raises pready
    genvar g;
    generate
        for (g = 0; g < NUM_WREG; g++) begin : gen_regs
            assign addrHit[g] = wordAligned && (regIdx == WREG_IDX[g]);
            aims_byte_reg #(.RESET(WREG_RESET)) u_reg (
                .clk(clk),
                .rstn(rstn),
                .wrEn(apbCommit & pwrite & addrHit[g] & ~errReg),
                .wrData(pwdata[7:0]),
                .value(regVal[g])
            );
        end
    endgenerate

    // Sequencer state, declared early for status reads
    aims_state_t stateReg;
    aims_state_t stateNext;
    logic [3:0] slotIdxReg;
    logic [3:0] slotIdxNext;
    logic [7:0] frameCntReg;

    // Read-only status bytes
    wire hitStatus = wordAligned && (regIdx == IDX_STATUS);
    wire hitFrames = wordAligned && (regIdx == IDX_FRAMES);
    wire anyHit = (|addrHit) | hitStatus | hitFrames;
    wire [7:0] statusByte = {2'b00, stateReg, slotIdxReg};

    // Read mux; a read-only byte ignores writes but answers without error
    logic [7:0] wregRead;
    always_comb begin
        wregRead = 8'h00;
        for (int i = 0; i < NUM_WREG; i++) begin
            if (addrHit[i]) begin
                wregRead = regVal[i];
            end
        end
    end
    wire [7:0] readByte = hitStatus ? statusByte :
                          hitFrames ? frameCntReg : wregRead;

    assign readyNext = accessWait;

    // Bus answer flops
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            readyReg <= 1'b0;
            errReg <= 1'b0;
            rdataReg <= 32'h0000_0000;
        end else begin
            readyReg <= readyNext;
            if (accessWait) begin
                errReg <= ~anyHit;
                rdataReg <= {24'h00_0000, readByte};
            end
        end
    end

    assign pready = readyReg;
    assign pslverr = errReg;
    assign prdata = rdataReg;

    // ---------------- Configuration fields ----------------
    wire [3:0] countField = regVal[0][COUNT_LSB +: 4];
    wire [3:0] effCount = (countField > SLOT_MAX) ? SLOT_MAX : countField;
    wire [3:0] diffEn = regVal[W_DIFF][DIFF_LSB +: 4];
    wire [2:0] remoteEn = regVal[W_REMOTE][REMOTE_LSB +: 3];
    wire preampEn = regVal[W_PREAMP][PREAMP_BIT];
    wire runEn = regVal[W_CONTROL][RUN_BIT];

    // Slot n lives in byte 5 - n/2, low nibble for even n
    logic [3:0] slotSel [NUM_SLOTS];
    generate
        for (g = 0; g < NUM_SLOTS; g++) begin : gen_slots
            assign slotSel[g] = regVal[5 - g / 2][(g % 2) * 4 +: 4];
        end
    endgenerate

    // Source check for the current slot
    wire slotInFrame = (slotIdxReg < effCount);
    wire [3:0] curSel = slotInFrame ? slotSel[slotIdxReg] : SRC_FIRST_PAIR;
    wire isCurrent = (curSel < SRC_PHASE_A);
    wire [1:0] pairIdx = curSel[2:1];
    wire [3:0] remoteVec = {remoteEn, 1'b0};
    // Remote pairs never reach the local converter
    wire remoteHit = isCurrent && remoteVec[pairIdx];
    // Odd half of a differential pair is already used by the pair
    wire oddHalf = isCurrent && diffEn[pairIdx] && curSel[0];
    wire srcUsable = (curSel <= SRC_PHASE_C) && !remoteHit && !oddHalf;

    // ---------------- Sequencer ----------------
    logic startReg;
    logic doneReg;
    logic [3:0] muxSelReg;
    logic [NUM_SLOTS-1:0] oneHotReg;

    // Next state: skip unusable slots, convert usable ones, wrap at the count
    always_comb begin
        stateNext = stateReg;
        slotIdxNext = slotIdxReg;
        case (stateReg)
            ST_IDLE: begin
                slotIdxNext = SLOT_ZERO;
                if (runEn && effCount != SLOT_ZERO) begin
                    stateNext = ST_PICK;
                end
            end
            ST_PICK: begin
                if (!slotInFrame) begin
                    slotIdxNext = SLOT_ZERO;
                    stateNext = (runEn && effCount != SLOT_ZERO) ? ST_PICK : ST_IDLE;
                end else if (srcUsable) begin
                    stateNext = ST_CONV;
                end else begin
                    slotIdxNext = slotIdxReg + 4'h1;
                end
            end
            ST_CONV: begin
                if (convDone) begin
                    slotIdxNext = slotIdxReg + 4'h1;
                    stateNext = ST_PICK;
                end
            end
            default: begin
                stateNext = ST_IDLE;
                slotIdxNext = SLOT_ZERO;
            end
        endcase
    end

    wire goConv = (stateReg == ST_PICK) && slotInFrame && srcUsable;
    wire wrapNow = (stateReg == ST_PICK) && !slotInFrame;

    // State and slot index
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            stateReg <= ST_IDLE;
            slotIdxReg <= SLOT_ZERO;
        end else begin
            stateReg <= stateNext;
            slotIdxReg <= slotIdxNext;
        end
    end

    // Converter request and routing; routing holds through the conversion
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            startReg <= 1'b0;
            doneReg <= 1'b0;
            muxSelReg <= SRC_FIRST_PAIR;
            oneHotReg <= '0;
        end else begin
            startReg <= goConv;
            doneReg <= wrapNow;
            if (goConv) begin
                muxSelReg <= curSel;
                oneHotReg <= NUM_SLOTS'(1) << curSel;
            end
        end
    end

    // Completed frames, visible to software
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            frameCntReg <= 8'h00;
        end else if (wrapNow) begin
            frameCntReg <= frameCntReg + 8'h01;
        end
    end

    // Front-end controls, copied to flops so outputs stay glitch free
    logic gainReg;
    logic [3:0] diffReg;
    logic [2:0] remoteReg;
    logic [1:0] filtReg;
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            gainReg <= 1'b0;
            diffReg <= 4'h0;
            remoteReg <= 3'h0;
            filtReg <= 2'h0;
        end else begin
            gainReg <= preampEn;
            diffReg <= diffEn;
            remoteReg <= remoteEn;
            filtReg <= regVal[W_DIFF][FILT_LSB +: 2];
        end
    end

    // ---------------- Engine memory write-back ----------------
    // Local results win; a colliding remote sample waits one cycle.
    // Limitation: a pending sample is lost if a local result and a new remote sample arrive in the same cycle.
    logic pendReg;
    logic [1:0] pendChanReg;
    logic [SAMPLE_W-1:0] pendDataReg;
    logic weReg;
    logic [3:0] waddrReg;
    logic [SAMPLE_W-1:0] wdataReg;
    wire localWr = (stateReg == ST_CONV) && convDone;
    wire [3:0] remAddr = CE_REMOTE_BASE + {2'b00, remoteChan};
    wire [3:0] pendAddr = CE_REMOTE_BASE + {2'b00, pendChanReg};

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            weReg <= 1'b0;
            waddrReg <= 4'h0;
            wdataReg <= '0;
            pendReg <= 1'b0;
            pendChanReg <= 2'h0;
            pendDataReg <= '0;
        end else begin
            weReg <= localWr | pendReg | remoteValid;
            if (localWr) begin
                waddrReg <= slotIdxReg;
                wdataReg <= convData;
                if (remoteValid) begin
                    pendReg <= 1'b1;
                    pendChanReg <= remoteChan;
                    pendDataReg <= remoteData;
                end
            end else if (pendReg) begin
                waddrReg <= pendAddr;
                wdataReg <= pendDataReg;
                pendReg <= remoteValid;
                if (remoteValid) begin
                    pendChanReg <= remoteChan;
                    pendDataReg <= remoteData;
                end
            end else if (remoteValid) begin
                waddrReg <= remAddr;
                wdataReg <= remoteData;
            end
        end
    end

    // Output hookup, every one straight from a flop
    assign convStart = startReg;
    assign muxSelect = muxSelReg;
    assign muxOneHot = oneHotReg;
    assign preampGain8 = gainReg;
    assign pairDifferential = diffReg;
    assign pairRemote = remoteReg;
    assign filterLength = filtReg;
    assign frameDone = doneReg;
    assign ceWriteEn = weReg;
    assign ceWriteAddr = waddrReg;
    assign ceWriteData = wdataReg;

    // ---------------- Assertions ----------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);

    sequence s_conv_end;
        (stateReg == ST_CONV) && convDone;
    endsequence

    sequence s_remote_free;
        remoteValid && !localWr && !pendReg;
    endsequence

    a_start_in_frame: assert property (
        convStart |-> (stateReg == ST_CONV) && (muxSelect <= SRC_PHASE_C)
            && ($past(slotIdxReg) < effCount))
        else $error("conversion started outside the frame");

    a_frame_wraps: assert property (
        frameDone |-> (slotIdxReg == SLOT_ZERO) && $past(slotIdxReg) >= $past(effCount))
        else $error("frame did not wrap to slot zero");

    a_slot_limit: assert property (
        (stateReg == ST_CONV) |-> (slotIdxReg < effCount) && (effCount <= SLOT_MAX))
        else $error("converting a slot past the count");

    a_remote_skip: assert property (
        convStart && (muxSelect < SRC_PHASE_A) && (muxSelect[2:1] != 2'b00)
            |-> !pairRemote[muxSelect[2:1] - 2'b01])
        else $error("remote pair routed to local converter");

    a_diff_odd: assert property (
        convStart && (muxSelect < SRC_PHASE_A) |->
            !(pairDifferential[muxSelect[2:1]] && muxSelect[0]))
        else $error("odd half of a differential pair converted");

    a_voltage_route: assert property (
        convStart && (muxSelect >= SRC_PHASE_A) |->
            muxOneHot[muxSelect] && $onehot(muxOneHot))
        else $error("phase voltage select not routed");

    a_gain_follow: assert property (
        $changed(preampEn) |=> (preampGain8 == $past(preampEn)))
        else $error("pre-amplifier gain not applied");

    a_slot_advance: assert property (
        s_conv_end |=> (slotIdxReg == $past(slotIdxReg) + 4'h1) && (stateReg == ST_PICK))
        else $error("slot did not advance after conversion");

    a_remote_bypass: assert property (
        s_remote_free |=> ceWriteEn && (ceWriteAddr == CE_REMOTE_BASE + {2'b00,
            $past(remoteChan)}) && (ceWriteData == $past(remoteData)))
        else $error("remote sample not written to engine memory");

    a_local_write: assert property (
        s_conv_end ##0 (!pendReg) |=> ceWriteEn && (ceWriteAddr == $past(slotIdxReg)))
        else $error("local sample not written to its slot");
endmodule : aims_top

// ===== aims_conv_model.sv
// Behavioural model of the shared converter facing the sequencer
module aims_conv_model #(
    parameter int SAMPLE_W = 24
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic convStart,
    input wire logic [3:0] muxSelect,
    input wire logic slow,
    output logic convDone,
    output logic [SAMPLE_W-1:0] convData
);
    timeunit 1ns;
    timeprecision 100ps;
    logic busy;
    logic [3:0] waitCnt;
    logic [3:0] selHeld;

    // Latch the source at start, answer after 2 or 10 cycles; data scrambles when not valid
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            busy <= 1'b0;
            waitCnt <= 4'h0;
            selHeld <= 4'h0;
            convDone <= 1'b0;
            convData <= '0;
        end else begin
            convDone <= 1'b0;
            convData <= ~convData;
            if (convStart) begin
                busy <= 1'b1;
                selHeld <= muxSelect;
                waitCnt <= slow ? 4'h9 : 4'h1;
            end else if (busy && waitCnt == 4'h0) begin
                busy <= 1'b0;
                convDone <= 1'b1;
                convData <= SAMPLE_W'({20'h3_C5A1, selHeld}); // Source code in low nibble
            end else if (busy) begin
                waitCnt <= waitCnt - 4'h1;
            end
        end
    end
endmodule : aims_conv_model

// ===== aims_top_test.sv
// Self-checking bench for the input multiplexer sequencer
module aims_top_test;
    timeunit 1ns;
    timeprecision 100ps;
    import aims_pkg::*;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, slow = 1'b0;
    logic [15:0] paddr = 16'h0000;
    logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
    logic pready, pslverr, er, convDone, convStart, preampGain8, frameDone, ceWriteEn;
    logic [23:0] convData, ceWriteData;
    logic remoteValid = 1'b0;
    logic [1:0] remoteChan = 2'b00, filterLength;
    logic [23:0] remoteData = 24'h00_0000;
    logic [3:0] muxSelect, pairDifferential, ceWriteAddr;
    logic [NUM_SLOTS-1:0] muxOneHot;
    logic [2:0] pairRemote;
    int n_mismatch = 0;
    int tests_run = 0;

    aims_top aims_top_i (.clk(clk), .rstn(rstn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .convDone(convDone), .convData(convData),
        .remoteValid(remoteValid), .remoteChan(remoteChan), .remoteData(remoteData),
        .convStart(convStart), .muxSelect(muxSelect), .muxOneHot(muxOneHot),
        .preampGain8(preampGain8), .pairDifferential(pairDifferential),
        .pairRemote(pairRemote), .filterLength(filterLength), .frameDone(frameDone),
        .ceWriteEn(ceWriteEn), .ceWriteAddr(ceWriteAddr), .ceWriteData(ceWriteData));
    aims_conv_model aims_conv_model_i (.clk(clk), .rstn(rstn), .convStart(convStart),
        .muxSelect(muxSelect), .slow(slow), .convDone(convDone), .convData(convData));

    // 200 MHz clock
    always #2.5 clk = ~clk;

    task results;
        $display("tests_run=%0d n_mismatch=%0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : results

    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task hang(input string nm);
        n_mismatch++;
        $display("CHECK FAILED %s expected handshake seen none", nm);
        results();
    endtask : hang

    task do_reset;
        rstn <= 1'b0;
        repeat (6) @(posedge clk);
        rstn <= 1'b1;
    endtask : do_reset

    // One APB transfer; held until pready is sampled high
    task apb(input logic wr, input logic [15:0] a, input logic [31:0] wd);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 40);
        if (pready !== 1'b1) hang("pready");
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask : apb

    // Program slots, count, front end, then set run
    task cfg(input logic [43:0] c, input logic [3:0] cnt, input logic [7:0] d, p, r);
        for (int j = 0; j < 5; j++) apb(1'b1, {IDX_S0_S1 - 14'(j), 2'b00}, 32'(c[8*j +: 8]));
        apb(1'b1, {IDX_COUNT_S10, 2'b00}, {24'h00_0000, cnt, c[43:40]});
        apb(1'b1, {IDX_DIFF_FILT, 2'b00}, {24'h00_0000, d});
        apb(1'b1, {IDX_PREAMP, 2'b00}, {24'h00_0000, p});
        apb(1'b1, {IDX_REMOTE, 2'b00}, {24'h00_0000, r});
        apb(1'b1, {IDX_CONTROL, 2'b00}, 32'h0000_0001);
    endtask : cfg

    // Next conversion must pick code s and write engine slot a
    task conv(input logic [3:0] s, input logic [3:0] a);
        int n;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (convStart !== 1'b1 && n < 200);
        if (convStart !== 1'b1) hang("convStart");
        chk("muxSelect", 32'(s), 32'(muxSelect));
        chk("muxOneHot", 32'(NUM_SLOTS'(1) << s), 32'(muxOneHot));
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (ceWriteEn !== 1'b1 && n < 200);
        if (ceWriteEn !== 1'b1) hang("ceWriteEn");
        chk("ceWriteAddr", 32'(a), 32'(ceWriteAddr));
        chk("ceWriteData", {8'h00, 20'h3_C5A1, s}, 32'(ceWriteData));
    endtask : conv

    // Frame must wrap with no further conversion first
    task wrap;
        int n;
        n = 0;
        do begin
            @(posedge clk);
            n++;
            chk("extra conversion", 32'h0000_0000, 32'(convStart));
        end while (frameDone !== 1'b1 && n < 100);
        if (frameDone !== 1'b1) hang("frameDone");
    endtask : wrap

    // Reset values, read-back, refused addresses
    task t_regs;
        chk("muxOneHot at reset", 32'h0000_0000, 32'(muxOneHot));
        for (int i = 0; i < NUM_WREG; i++) begin
            apb(1'b0, {WREG_IDX[i], 2'b00}, 32'h0000_0000);
            chk("reset value", {24'h00_0000, WREG_RESET}, rd);
            if (i != W_CONTROL) begin
                apb(1'b1, {WREG_IDX[i], 2'b00}, {24'hFF_FFFF, 8'(8'h5A ^ i)});
                apb(1'b0, {WREG_IDX[i], 2'b00}, 32'h0000_0000);
                chk("read back", {24'h00_0000, 8'(8'h5A ^ i)}, rd);
                chk("pslverr", 32'h0000_0000, 32'(er));
            end
        end
        apb(1'b0, 16'h8418, 32'h0000_0000);
        chk("unmapped err", 32'h0000_0001, 32'(er));
        chk("unmapped data", 32'h0000_0000, rd);
        apb(1'b1, 16'h8401, 32'h0000_00FF);
        chk("unaligned err", 32'h0000_0001, 32'(er));
    endtask : t_regs

    // Front-end control levels follow their register bits
    task t_level(input logic [7:0] d, p, r);
        apb(1'b1, {IDX_DIFF_FILT, 2'b00}, {24'h00_0000, d});
        apb(1'b1, {IDX_PREAMP, 2'b00}, {24'h00_0000, p});
        apb(1'b1, {IDX_REMOTE, 2'b00}, {24'h00_0000, r});
        repeat (2) @(posedge clk);
        chk("pairDifferential", 32'(d[DIFF_LSB +: 4]), 32'(pairDifferential));
        chk("filterLength", 32'(d[FILT_LSB +: 2]), 32'(filterLength));
        chk("preampGain8", 32'(p[PREAMP_BIT]), 32'(preampGain8));
        chk("pairRemote", 32'(r[REMOTE_LSB +: 3]), 32'(pairRemote));
    endtask : t_level

    // Remote samples go straight to engine memory
    task t_remote;
        for (int k = 0; k < 3; k++) begin
            remoteValid <= 1'b1;
            remoteChan <= 2'(k);
            remoteData <= 24'h81_0000 | 24'(k);
            @(posedge clk);
            remoteValid <= 1'b0;
            @(posedge clk);
            chk("remote write", 32'h0000_0001, 32'(ceWriteEn));
            chk("remote addr", 32'(CE_REMOTE_BASE + 4'(k)), 32'(ceWriteAddr));
            chk("remote data", 32'h0081_0000 | 32'(k), 32'(ceWriteData));
        end
    endtask : t_remote

    // One local and three remote shunts; slow converter on the second frame
    // Slot 1 is the odd half of the differential first pair, slot 2 a remote pair
    task t_shunt;
        cfg(44'h000_08A9_8210, 4'h6, 8'h10, 8'h20, 8'h38);
        for (int f = 0; f < 2; f++) begin
            slow <= f[0];
            conv(SRC_FIRST_PAIR, 4'h0);
            conv(SRC_PHASE_A, 4'h3);
            conv(SRC_PHASE_B, 4'h4);
            conv(SRC_PHASE_C, 4'h5);
            wrap();
        end
        conv(SRC_FIRST_PAIR, 4'h0);
        // Two wraps so far; the frame counter is read-only and error free
        apb(1'b0, {IDX_FRAMES, 2'b00}, 32'h0000_0000);
        chk("frames read", 32'h0000_0002, rd);
        chk("frames pslverr", 32'h0000_0000, 32'(er));
    endtask : t_shunt

    // Eleven single-ended sources in one frame
    task t_single;
        cfg(44'hA98_7654_3210, 4'hB, 8'h00, 8'h00, 8'h00);
        for (int k = 0; k < NUM_SLOTS; k++) conv(4'(k), 4'(k));
        wrap();
        conv(SLOT_ZERO, 4'h0);
    endtask : t_single

    initial begin
        do_reset();
        t_regs();
        t_level(8'hF6, 8'h20, 8'h38);
        t_level(8'h52, 8'h00, 8'h10);
        t_remote();
        do_reset();
        t_shunt();
        do_reset();
        t_single();
        results();
    end
endmodule : aims_top_test
